// ### design/ffpm_map.svh
// Purpose: Offsets, field positions, reset values and timing of the PM block.
// Assumes: Included by bare name; definitions only.
// Notes: Summary of operation below.
// Summary of operation
// - Timer count read-only, live, resets 00FFFFFC
// - Timer ticks at 14.31818 MHz over four
// - Timer MSB toggle raises SMI when enabled
// - Timer SMI recorded in SMI status bit 0
// - Block decoded at relocatable base AC00h
// - Event block: status word then enable word
// - Control block: one 16-bit control register
// - Processor block: throttle control, C2 port
// - Bit 4 enables throttling; reserved bits zero
// - Duty code gives code times 12.5 percent
// - Duty field three bits wide at bit 0
// - Reading C2 port enters C2 state
// - C2 port reads zero, ignores writes
// - Command port at 06h forwards OS commands
// - Index/data pair maps pins to status bits
// - General event block: status then enable
// - General status raises SCI only if enabled
// - Timer bit 23 toggle sets status, SCI
// - Status bits sticky, write one clears
`ifndef FFPM_MAP_SVH
`define FFPM_MAP_SVH

// ==========================================================
// Register offsets from the relocatable base; the timer port is an absolute address
`define FFPM_BASE_DEFAULT 16'hac00
`define FFPM_OFF_THROTTLE 16'h0000
`define FFPM_OFF_C2 16'h0004
`define FFPM_OFF_RSVD5 16'h0005
`define FFPM_OFF_CMD 16'h0006
`define FFPM_OFF_PM_STS 16'h0008
`define FFPM_OFF_PM_EN 16'h000a
`define FFPM_OFF_PM_CNT 16'h000c
`define FFPM_OFF_CFG_IDX 16'h000e
`define FFPM_OFF_GEN_STS 16'h0010
`define FFPM_OFF_GEN_EN 16'h0012
`define FFPM_OFF_CFG_DATA 16'h0014
`define FFPM_TIMER_PORT 16'h121c

// ==========================================================
// Fields and reset values
`define FFPM_TIMER_W 24
`define FFPM_TIMER_RESET 24'hfffffc
`define FFPM_TIMER_MSB 23
`define FFPM_THR_EN_BIT 4
`define FFPM_DUTY_LSB 0
`define FFPM_DUTY_W 3
`define FFPM_PM_TMR_BIT 0
`define FFPM_CNT_SCI_EN 0
`define FFPM_CNT_GBL_RLS 2
`define FFPM_CNT_TYP_LSB 10
`define FFPM_CNT_SLP_EN 13
`define FFPM_CFG_IDX_FIRST 16'h0010
`define FFPM_MAP_VALID 7
`define FFPM_MAP_TARGET 6

// ==========================================================
// Timing
`define FFPM_CLK_HZ 125000000
`define FFPM_REF_HZ 14318180
`define FFPM_REF_DIV 4
`define FFPM_THR_STEP_NS 1000
`define FFPM_CLK_NS 8
`define FFPM_THR_STEP_CYC ((`FFPM_THR_STEP_NS + `FFPM_CLK_NS - 1) / `FFPM_CLK_NS)

`endif

// ### design/ffpm_pkg.sv
// Purpose: Shared types of the PM block.
// Assumes: Used with scope prefix, never imported.
// Notes: Constants live in ffpm_map.svh.
package ffpm_pkg;

	// ==========================================================
	// Types
	typedef logic [15:0] ffpm_word_t;
	typedef enum logic {
		FFPM_TGT_PM = 1'b0,
		FFPM_TGT_GEN = 1'b1
	} ffpm_target_e;

endpackage : ffpm_pkg

// ### design/ffpm_timer.sv
// Purpose: Free-running 24-bit PM timer with fractional tick generator.
// Assumes: clock at `FFPM_CLK_HZ.
// Notes: Tick jitter is one clock; long-term rate is exact.
`include "ffpm_map.svh"

module ffpm_timer (
	input wire logic clock,
	input wire logic rst_n,
	output logic [`FFPM_TIMER_W-1:0] value,
	output logic msb_toggle
);

	// ==========================================================
	// Phase accumulator
	localparam logic [27:0] INC = 28'(`FFPM_REF_HZ / `FFPM_REF_DIV);
	localparam logic [27:0] WRAP = 28'(`FFPM_CLK_HZ);

	logic [27:0] acc_q;
	logic [`FFPM_TIMER_W-1:0] cnt_q;
	logic tog_q;

	wire [27:0] acc_sum = acc_q + INC;
	wire tick = acc_sum >= WRAP;
	wire [27:0] acc_d = tick ? acc_sum - WRAP : acc_sum;
	// Wraps from all ones to zero by width
	wire [`FFPM_TIMER_W-1:0] cnt_d = tick ? cnt_q + 1'b1 : cnt_q;
	wire flip = cnt_d[`FFPM_TIMER_MSB] != cnt_q[`FFPM_TIMER_MSB];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			cnt_q <= `FFPM_TIMER_RESET;
			tog_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			tog_q <= flip;
		end
	end

	assign value = cnt_q;
	assign msb_toggle = tog_q;

endmodule : ffpm_timer

// ### design/ffpm_evt_bank.sv
// Purpose: Sticky status word with enable word and pending summary.
// Assumes: Strobes are single-cycle from the same clock.
// Notes: A set in the clearing cycle survives the clear.
module ffpm_evt_bank #(
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] set,
	input wire logic sts_wr,
	input wire logic en_wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] status,
	output logic [W-1:0] enable,
	output logic pending
);

	// ==========================================================
	// Storage
	logic [W-1:0] sts_q;
	logic [W-1:0] en_q;

	wire [W-1:0] clr = sts_wr ? wdata : '0;
	wire [W-1:0] sts_d = (sts_q & ~clr) | set;
	wire [W-1:0] en_d = en_wr ? wdata : en_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= '0;
			en_q <= '0;
		end else begin
			sts_q <= sts_d;
			en_q <= en_d;
		end
	end

	assign status = sts_q;
	assign enable = en_q;
	assign pending = |(sts_q & en_q);

endmodule : ffpm_evt_bank

// ### design/ffpm_pm_block.sv
// Purpose: Fixed-feature power-management register block on the I/O port.
// Assumes: io_rd/io_wr are one-cycle strobes on clock; data in low bits.
// Notes: Software must honour each register's width; sizes are not checked.
`include "ffpm_map.svh"

module ffpm_pm_block #(
	parameter logic [15:0] BASE = `FFPM_BASE_DEFAULT,
	parameter int GPIO_W = 8,
	parameter int STEP_CYCLES = `FFPM_THR_STEP_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [31:0] io_wdata,
	output logic [31:0] io_rdata,
	output logic io_ack,
	input wire logic [GPIO_W-1:0] gpio_in,
	input wire logic timer_smi_enable,
	input wire logic smi_status_clear,
	output logic smi,
	output logic smi_timer_status,
	output logic sci,
	output logic c2_enter,
	output logic os_cmd_valid,
	output logic [7:0] os_cmd_data,
	output logic sleep_req,
	output logic [2:0] sleep_type,
	output logic global_release,
	output logic sci_enable,
	output logic cpu_clock_stop
);

	// ==========================================================
	// Address decode
	function automatic logic at(input logic [15:0] rel, input logic [15:0] off);
		return rel == off;
	endfunction : at

	// Relative offsets follow a relocated base
	wire [15:0] rel = io_addr - BASE;
	wire hit_thr = at(rel, `FFPM_OFF_THROTTLE);
	wire hit_c2 = at(rel, `FFPM_OFF_C2);
	wire hit_rsvd = at(rel, `FFPM_OFF_RSVD5);
	wire hit_cmd = at(rel, `FFPM_OFF_CMD);
	wire hit_pm_sts = at(rel, `FFPM_OFF_PM_STS);
	wire hit_pm_en = at(rel, `FFPM_OFF_PM_EN);
	wire hit_pm_cnt = at(rel, `FFPM_OFF_PM_CNT);
	wire hit_idx = at(rel, `FFPM_OFF_CFG_IDX);
	wire hit_gen_sts = at(rel, `FFPM_OFF_GEN_STS);
	wire hit_gen_en = at(rel, `FFPM_OFF_GEN_EN);
	wire hit_data = at(rel, `FFPM_OFF_CFG_DATA);
	wire hit_timer = io_addr == `FFPM_TIMER_PORT;

	wire wr_thr = io_wr & hit_thr;
	wire wr_cmd = io_wr & hit_cmd;
	wire wr_cnt = io_wr & hit_pm_cnt;
	wire wr_idx = io_wr & hit_idx;
	wire wr_data = io_wr & hit_data;

	// ==========================================================
	// Processor throttle control
	logic thr_en_q;
	logic [`FFPM_DUTY_W-1:0] duty_q;
	wire thr_en_d = wr_thr ? io_wdata[`FFPM_THR_EN_BIT] : thr_en_q;
	wire [`FFPM_DUTY_W-1:0] duty_d = wr_thr ?
		io_wdata[`FFPM_DUTY_LSB +: `FFPM_DUTY_W] : duty_q;

	// Eight phases per throttle period; the CPU runs duty of them
	logic [15:0] step_q;
	logic [2:0] phase_q;
	logic stop_q;
	wire step_end = step_q == 16'(STEP_CYCLES - 1);
	wire [15:0] step_d = step_end ? '0 : step_q + 16'h0001;
	wire [2:0] phase_d = step_end ? phase_q + 3'h1 : phase_q;
	// Code zero is reserved and leaves the clock running
	wire stop_d = thr_en_q & (duty_q != '0) & (phase_q >= duty_q);

	// ==========================================================
	// C2 entry, command port, control register
	logic c2_q;
	logic [7:0] cmd_q;
	logic cmd_v_q;
	logic sci_en_q;
	logic [2:0] typ_q;
	logic slp_q;
	logic rls_q;
	wire c2_d = io_rd & hit_c2;
	wire [7:0] cmd_d = wr_cmd ? io_wdata[7:0] : cmd_q;
	wire sci_en_d = wr_cnt ? io_wdata[`FFPM_CNT_SCI_EN] : sci_en_q;
	wire [2:0] typ_d = wr_cnt ? io_wdata[`FFPM_CNT_TYP_LSB +: 3] : typ_q;
	wire slp_d = wr_cnt & io_wdata[`FFPM_CNT_SLP_EN];
	wire rls_d = wr_cnt & io_wdata[`FFPM_CNT_GBL_RLS];

	// ==========================================================
	// Setup index/data and pin map
	logic [15:0] idx_q;
	logic [7:0] map_q [GPIO_W];
	wire [15:0] idx_rel = io_wdata[15:0] - `FFPM_CFG_IDX_FIRST;
	wire [15:0] cur_rel = idx_q - `FFPM_CFG_IDX_FIRST;
	// Undefined indices are dropped on write
	wire idx_ok_wr = idx_rel < 16'(GPIO_W);
	wire cur_ok = cur_rel < 16'(GPIO_W);
	wire [15:0] idx_d = (wr_idx & idx_ok_wr) ? io_wdata[15:0] : idx_q;
	wire [7:0] map_rd = cur_ok ? map_q[cur_rel[$clog2(GPIO_W)-1:0]] : 8'h00;

	// Pins cross three stages; a change counts once stages two and three agree
	logic [GPIO_W-1:0] s1_q;
	logic [GPIO_W-1:0] s2_q;
	logic [GPIO_W-1:0] s3_q;
	logic [GPIO_W-1:0] lvl_q;
	wire [GPIO_W-1:0] agree = ~(s2_q ^ s3_q);
	wire [GPIO_W-1:0] lvl_d = (lvl_q & ~agree) | (s3_q & agree);
	wire [GPIO_W-1:0] rise = lvl_d & ~lvl_q;

	// ==========================================================
	// Events
	logic [`FFPM_TIMER_W-1:0] timer_val;
	logic timer_flip;
	logic [15:0] pm_sts;
	logic [15:0] pm_en;
	logic [15:0] gen_sts;
	logic [15:0] gen_en;
	logic pm_pend;
	logic gen_pend;
	logic [15:0] pin_pm_set;
	logic [15:0] pin_gen_set;

	always_comb begin
		pin_pm_set = '0;
		pin_gen_set = '0;
		for (int i = 0; i < GPIO_W; i++) begin
			if (rise[i] & map_q[i][`FFPM_MAP_VALID]) begin
				if (map_q[i][`FFPM_MAP_TARGET] == ffpm_pkg::FFPM_TGT_GEN) begin
					pin_gen_set[map_q[i][3:0]] = 1'b1;
				end else begin
					pin_pm_set[map_q[i][3:0]] = 1'b1;
				end
			end
		end
	end

	wire [15:0] tmr_set = timer_flip ? 16'(1 << `FFPM_PM_TMR_BIT) : 16'h0000;
	wire [15:0] pm_set = pin_pm_set | tmr_set;

	ffpm_timer u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.value(timer_val),
		.msb_toggle(timer_flip)
	);

	ffpm_evt_bank #(.W(16)) u_pm_evt (
		.clock(clock),
		.rst_n(rst_n),
		.set(pm_set),
		.sts_wr(io_wr & hit_pm_sts),
		.en_wr(io_wr & hit_pm_en),
		.wdata(io_wdata[15:0]),
		.status(pm_sts),
		.enable(pm_en),
		.pending(pm_pend)
	);

	ffpm_evt_bank #(.W(16)) u_gen_evt (
		.clock(clock),
		.rst_n(rst_n),
		.set(pin_gen_set),
		.sts_wr(io_wr & hit_gen_sts),
		.en_wr(io_wr & hit_gen_en),
		.wdata(io_wdata[15:0]),
		.status(gen_sts),
		.enable(gen_en),
		.pending(gen_pend)
	);

	// SMI on timer MSB toggle or global lock release; status set wins over clear
	logic smi_q;
	logic smi_sts_q;
	logic sci_q;
	wire tmr_smi = timer_flip & timer_smi_enable;
	wire smi_d = tmr_smi | rls_d;
	wire smi_sts_d = tmr_smi | (smi_sts_q & ~smi_status_clear);
	wire sci_d = pm_pend | gen_pend;

	// ==========================================================
	// Read path
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_timer) begin
			rd_mux = {8'h00, timer_val};
		end else if (hit_thr) begin
			rd_mux[`FFPM_THR_EN_BIT] = thr_en_q;
			rd_mux[`FFPM_DUTY_LSB +: `FFPM_DUTY_W] = duty_q;
		end else if (hit_cmd) begin
			rd_mux[7:0] = cmd_q;
		end else if (hit_pm_sts) begin
			rd_mux[15:0] = pm_sts;
		end else if (hit_pm_en) begin
			rd_mux[15:0] = pm_en;
		end else if (hit_pm_cnt) begin
			// Sleep enable and lock release are write-only, read zero
			rd_mux[`FFPM_CNT_SCI_EN] = sci_en_q;
			rd_mux[`FFPM_CNT_TYP_LSB +: 3] = typ_q;
		end else if (hit_idx) begin
			rd_mux[15:0] = idx_q;
		end else if (hit_gen_sts) begin
			rd_mux[15:0] = gen_sts;
		end else if (hit_gen_en) begin
			rd_mux[15:0] = gen_en;
		end else if (hit_data) begin
			rd_mux[7:0] = map_rd;
		end else begin
			// C2 port, reserved byte and unmapped addresses read zero
			rd_mux = 32'h0000_0000;
		end
	end

	logic [31:0] rdata_q;
	logic ack_q;
	wire [31:0] rdata_d = io_rd ? rd_mux : rdata_q;
	wire ack_d = io_rd | io_wr;

	// ==========================================================
	// Registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thr_en_q <= 1'b0;
			duty_q <= '0;
			step_q <= '0;
			phase_q <= '0;
			stop_q <= 1'b0;
		end else begin
			thr_en_q <= thr_en_d;
			duty_q <= duty_d;
			step_q <= step_d;
			phase_q <= phase_d;
			stop_q <= stop_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			c2_q <= 1'b0;
			cmd_q <= 8'h00;
			cmd_v_q <= 1'b0;
			sci_en_q <= 1'b0;
			typ_q <= 3'h0;
			slp_q <= 1'b0;
			rls_q <= 1'b0;
		end else begin
			c2_q <= c2_d;
			cmd_q <= cmd_d;
			cmd_v_q <= wr_cmd;
			sci_en_q <= sci_en_d;
			typ_q <= typ_d;
			slp_q <= slp_d;
			rls_q <= rls_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 16'h0000;
			for (int i = 0; i < GPIO_W; i++) begin
				map_q[i] <= 8'h00;
			end
		end else begin
			idx_q <= idx_d;
			if (wr_data & cur_ok) begin
				map_q[cur_rel[$clog2(GPIO_W)-1:0]] <= io_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= gpio_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			smi_q <= 1'b0;
			smi_sts_q <= 1'b0;
			sci_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			smi_q <= smi_d;
			smi_sts_q <= smi_sts_d;
			sci_q <= sci_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// ==========================================================
	// Outputs
	assign io_rdata = rdata_q;
	assign io_ack = ack_q;
	assign smi = smi_q;
	assign smi_timer_status = smi_sts_q;
	assign sci = sci_q;
	assign c2_enter = c2_q;
	assign os_cmd_valid = cmd_v_q;
	assign os_cmd_data = cmd_q;
	assign sleep_req = slp_q;
	assign sleep_type = typ_q;
	assign global_release = rls_q;
	assign sci_enable = sci_en_q;
	assign cpu_clock_stop = stop_q;

endmodule : ffpm_pm_block

// ### verification/ffpm_pm_block_monitor.sv
// Purpose: Port-level checks of the PM register block.
// Assumes: Bound into every ffpm_pm_block; strobes sampled on rising clock.
// Notes: Timer event timing is left to the bench.
module ffpm_pm_block_monitor #(
	parameter logic [15:0] BASE = 16'hac00
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [31:0] io_wdata,
	input wire logic [31:0] io_rdata,
	input wire logic io_ack,
	input wire logic smi,
	input wire logic smi_timer_status,
	input wire logic sci,
	input wire logic c2_enter,
	input wire logic os_cmd_valid,
	input wire logic [7:0] os_cmd_data,
	input wire logic sleep_req,
	input wire logic [2:0] sleep_type,
	input wire logic cpu_clock_stop
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ==========
	// Decode
	wire logic acc = io_rd | io_wr;
	wire logic c2_hit = io_addr == BASE + 16'h0004;
	wire logic wr_cmd = io_wr && io_addr == BASE + 16'h0006;
	wire logic rd_thr = io_rd && io_addr == BASE;
	wire logic rd_tmr = io_rd && io_addr == 16'h121c;
	wire logic wr_cnt = io_wr && io_addr == BASE + 16'h000c;
	// ==========
	// Checks
	a_ack_follows_access: assert property (acc |=> io_ack)
		else $error("no ack after access");
	a_ack_no_spurious: assert property (!acc |=> !io_ack)
		else $error("ack without access");
	a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved without read");
	a_c2_read_enters: assert property (io_rd && c2_hit |=> c2_enter && io_rdata == 32'h0)
		else $error("C2 read wrong");
	a_c2_write_ignored: assert property (io_wr && c2_hit |=> !c2_enter)
		else $error("C2 write had effect");
	a_cmd_forwarded: assert property (wr_cmd |=> os_cmd_valid && os_cmd_data == $past(io_wdata[7:0]))
		else $error("command not forwarded");
	a_cmd_only_write: assert property (!wr_cmd |=> !os_cmd_valid)
		else $error("spurious command");
	a_timer_upper_zero: assert property (rd_tmr |=> io_rdata[31:24] == 8'h00)
		else $error("timer upper bits set");
	a_throttle_rsvd_zero: assert property (rd_thr |=> io_rdata[31:5] == 27'h0 && !io_rdata[3])
		else $error("throttle reserved bits set");
	a_sleep_request: assert property (wr_cnt && io_wdata[13] |=> sleep_req && sleep_type == $past(io_wdata[12:10]))
		else $error("sleep request wrong");
	a_smi_source_flag: assert property ($rose(smi_timer_status) |-> smi || $past(smi))
		else $error("status flag without smi");
	c_c2: cover property (c2_enter);
	c_sci: cover property (sci);
	c_smi: cover property (smi_timer_status);
	c_stop: cover property (cpu_clock_stop);
endmodule : ffpm_pm_block_monitor

bind ffpm_pm_block ffpm_pm_block_monitor #(.BASE(BASE)) i_mon (
	.clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
	.io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .smi(smi),
	.smi_timer_status(smi_timer_status), .sci(sci), .c2_enter(c2_enter),
	.os_cmd_valid(os_cmd_valid), .os_cmd_data(os_cmd_data), .sleep_req(sleep_req),
	.sleep_type(sleep_type), .cpu_clock_stop(cpu_clock_stop)
);

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the PM register block.
// Assumes: Short throttle phase so a duty period is a few clocks.
// Notes: The only timer toggle reachable is the wrap just after reset.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
		$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
	localparam logic [15:0] B = 16'hac00;
	localparam int STEP = 2;
	logic clock = 0, rst_n = 0, io_rd = 0, io_wr = 0;
	logic timer_smi_enable = 1, smi_status_clear = 0;
	logic [15:0] io_addr = '0;
	logic [31:0] io_wdata = '0, io_rdata, q, w, t0;
	logic [7:0] gpio_in = '0, os_cmd_data;
	logic io_ack, smi, smi_timer_status, sci, c2_enter, os_cmd_valid;
	logic sleep_req, global_release, sci_enable, cpu_clock_stop;
	logic [2:0] sleep_type;
	logic [3:0] p;
	logic [23:0] dt;
	int miscompares = 0, tests_run = 0, n, k, c;
	int unsigned seed = 25087;

	always #4 clock = ~clock;

	ffpm_pm_block #(.BASE(B), .STEP_CYCLES(STEP)) i_dut (
		.clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .gpio_in(gpio_in),
		.timer_smi_enable(timer_smi_enable), .smi_status_clear(smi_status_clear),
		.smi(smi), .smi_timer_status(smi_timer_status), .sci(sci), .c2_enter(c2_enter),
		.os_cmd_valid(os_cmd_valid), .os_cmd_data(os_cmd_data), .sleep_req(sleep_req),
		.sleep_type(sleep_type), .global_release(global_release), .sci_enable(sci_enable),
		.cpu_clock_stop(cpu_clock_stop)
	);

	// ==========
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic int stop_exp(input logic en, input logic [2:0] d);
		return (en && d != 3'h0) ? (8 - int'(d)) * STEP : 0;
	endfunction : stop_exp

	task automatic close_out();
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// One strobe cycle; answer and pulses are sampled where the ack stands
	// Each access drives all 32 data bits whatever the register's width, data low-aligned
	task automatic io(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(negedge clock);
		io_addr = a;
		io_wr = wr;
		io_rd = !wr;
		io_wdata = d;
		@(negedge clock);
		io_rd = 0;
		io_wr = 0;
		q = io_rdata;
		p = {c2_enter, os_cmd_valid, sleep_req, global_release};
		`CHK(io_ack, 1'b1)
	endtask : io

	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		close_out();
	end

	// ==========
	// Scenarios
	initial begin
		repeat (16) @(negedge clock);
		rst_n = 1;
		io(0, 16'h121c, 0);
		`CHK(q, 32'h00fffffc)
		io(0, B, 0);
		`CHK(q, 32'h0)
		// Firmware start-up: clear general status, mask general events
		io(1, B + 16'h10, 32'hffff);
		io(1, B + 16'h12, 32'h0);
		io(0, B + 16'h10, 0);
		`CHK(q, 32'h0)
		io(1, B + 16'h0a, 1);
		// Wrap from all ones flips the top bit a few ticks after reset
		for (k = 0; k < 500 && sci !== 1'b1; k++) @(negedge clock);
		`CHK(sci, 1'b1)
		`CHK(smi_timer_status, 1'b1)
		io(1, B + 16'h08, 0);
		io(0, B + 16'h08, 0);
		`CHK(q[0], 1'b1)
		io(1, B + 16'h08, 1);
		io(0, B + 16'h08, 0);
		`CHK(q[0], 1'b0)
		`CHK(sci, 1'b0)
		smi_status_clear = 1;
		@(negedge clock);
		smi_status_clear = 0;
		@(negedge clock);
		`CHK(smi_timer_status, 1'b0)
		io(1, B + 16'h0a, 0);
		io(0, 16'h121c, 0);
		t0 = q;
		io(1, 16'h121c, xs());
		repeat (996) @(negedge clock);
		io(0, 16'h121c, 0);
		dt = q[23:0] - t0[23:0];
		`CHK(dt inside {[24'd28:24'd29]}, 1'b1)
		`CHK(q[31:24], 8'h00)
		for (n = 0; n < 16; n++) begin
			w = xs();
			w[4] = n[3];
			w[2:0] = n[2:0];
			io(1, B, w);
			io(0, B, 0);
			`CHK(q, {27'h0, w[4], 1'b0, w[2:0]})
			repeat (16 * STEP) @(negedge clock);
			c = 0;
			repeat (8 * STEP) begin
				@(negedge clock);
				c += int'(cpu_clock_stop === 1'b1);
			end
			`CHK(c, stop_exp(w[4], w[2:0]))
		end
		io(1, B, 0);
		for (n = 0; n < 4; n++) begin
			w = xs();
			io(1, B + 16'h06, w);
			`CHK(p, 4'b0100)
			`CHK(os_cmd_data, w[7:0])
			io(0, B + 16'h06, 0);
			`CHK(q, {24'h0, w[7:0]})
		end
		io(1, B + 16'h04, xs());
		`CHK(p, 4'b0000)
		io(0, B + 16'h04, 0);
		`CHK(p, 4'b1000)
		`CHK(q, 32'h0)
		io(0, B + 16'h05, 0);
		`CHK(q, 32'h0)
		io(0, B + 16'h40, 0);
		`CHK(q, 32'h0)
		io(1, B + 16'h0c, 32'h3405);
		`CHK(p, 4'b0011)
		`CHK(smi, 1'b1)
		`CHK(sleep_type, 3'b101)
		`CHK(sci_enable, 1'b1)
		io(0, B + 16'h0c, 0);
		`CHK(q[15:0], 16'h1401)
		io(1, B + 16'h0e, 32'h10);
		io(1, B + 16'h0e, 32'h30);
		io(0, B + 16'h0e, 0);
		`CHK(q[15:0], 16'h0010)
		io(1, B + 16'h14, 32'hc3);
		gpio_in[0] = 1;
		repeat (20) @(negedge clock);
		`CHK(sci, 1'b0)
		io(0, B + 16'h10, 0);
		`CHK(q[15:0], 16'h0008)
		io(1, B + 16'h12, 32'h8);
		repeat (2) @(negedge clock);
		`CHK(sci, 1'b1)
		io(1, B + 16'h10, 32'h8);
		repeat (2) @(negedge clock);
		`CHK(sci, 1'b0)
		// Second reset with the timer SMI masked: the wrap sets status but no SMI
		@(negedge clock);
		rst_n = 0;
		timer_smi_enable = 0;
		repeat (2) @(negedge clock);
		rst_n = 1;
		io(0, 16'h121c, 0);
		`CHK(q, 32'h00fffffc)
		io(1, B + 16'h0a, 1);
		for (k = 0; k < 500 && sci !== 1'b1; k++) @(negedge clock);
		`CHK(sci, 1'b1)
		`CHK(smi_timer_status, 1'b0)
		`CHK(smi, 1'b0)
		io(0, 16'h121c, 0);
		`CHK(q[31:24], 8'h00)
		close_out();
	end
endmodule : tb_top
